// ### bench/pbsel_pin_model.sv
/*
  Far side of the selector: the pads and peripherals that take the routes.
  Assumes routes are registered levels, steady between writes.
*/
`timescale 1ns/1ps
`default_nettype none
module pbsel_pin_model
    import pbsel_pkg::*;
(
    // routes from the selector
    input  wire pbsel_line3_route_t line3_in,
    input  wire pbsel_line2_route_t line2_in,
    input  wire pbsel_line1_route_t line1_in,
    input  wire pbsel_line0_route_t line0_in,
    // what the pads see, one word
    output logic [14:0]             seen_out
);
    // pads only follow, no feedback, so no wrong answers to model
    assign seen_out = {line3_in, line2_in, line1_in, line0_in};
endmodule // pbsel_pin_model
`default_nettype wire

// ### bench/tb.sv
/*
  Self-checking bench for the port B low selector.
  Assumes the pin model file is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pbsel_pkg::*;
    // expected route per field code, code 0 in the low slot
    localparam logic [11:0] T3 = {3'h4, 3'h1, 3'h2, 3'h4};
    localparam logic [15:0] T2 = 16'hC12C;
    localparam logic [15:0] T1 = 16'h1C2C;
    localparam logic [15:0] T0 = 16'h1248;
    logic clock_in = 0, reset_n_in = 0, clk_en_in = 1, reg_write_in = 0, reg_read_in = 0;
    logic rd_d = 0, wr_d = 0, ce_d = 0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, cur = 8'h00;
    logic [14:0] seen;
    logic [31:0] r;
    pbsel_line3_route_t l3;
    pbsel_line2_route_t l2;
    pbsel_line1_route_t l1;
    pbsel_line0_route_t l0;
    logic [7:0] dq[$];
    logic [14:0] rq[$];
    int seed = 94260, bad_count = 0, n_checks = 0, cycles = 0;
    pbsel_top u_pbsel_top (.clock_in(clock_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .line3_route_out(l3),
        .line2_route_out(l2), .line1_route_out(l1), .line0_route_out(l0));
    pbsel_pin_model u_pbsel_pin_model (.line3_in(l3), .line2_in(l2), .line1_in(l1),
        .line0_in(l0), .seen_out(seen));
    always #5 clock_in = ~clock_in;
    function automatic logic [14:0] exp_route(input logic [7:0] v);
        return {T3[v[7:6]*3 +: 3], T2[v[5:4]*4 +: 4], T1[v[3:2]*4 +: 4], T0[v[1:0]*4 +: 4]};
    endfunction
    // one bus cycle; expectations noted as the request goes out
    task automatic op(input logic w, rd, input logic [3:0] a, input logic [7:0] d, input logic en);
        @(posedge clock_in);
        reg_write_in <= w;
        reg_read_in <= rd;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        clk_en_in <= en;
        if (en && w && a == PBSEL_ADDR_SELECT) cur = d;
        if (en && w) rq.push_back(exp_route(cur));
        if (en && rd) dq.push_back(a == PBSEL_ADDR_SELECT ? cur : PBSEL_UNMAPPED_DATA);
    endtask
    task automatic chk8(input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic chk15(input logic [14:0] e, g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic end_of_test;
        // a note never matched means a result that did not show
        if (dq.size() != 0 || rq.size() != 0) bad_count++;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watcher: results stand the cycle after the accepted strobe
    always @(posedge clock_in) begin
        rd_d <= reg_read_in & clk_en_in & reset_n_in;
        wr_d <= reg_write_in & clk_en_in & reset_n_in;
        ce_d <= clk_en_in & reset_n_in;
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            end_of_test();
        end
    end
    always @(negedge clock_in) if (reset_n_in) begin
        if (rd_d) chk8(dq.pop_front(), reg_rdata_out);
        else if (ce_d) chk8(PBSEL_UNMAPPED_DATA, reg_rdata_out);
        if (wr_d) chk15(rq.pop_front(), seen);
    end
    initial begin
        repeat (10) @(posedge clock_in);
        reset_n_in <= 1'b1;
        op(0, 1, 4'h0, 8'h00, 1); // reset value read back
        for (int i = 0; i < 4; i++) begin
            op(1, 0, 4'h0, {4{i[1:0]}}, 1);
            op(0, 1, 4'h0, 8'h00, 1);
        end
        op(0, 1, 4'hF, 8'h00, 1); // unmapped read gives zero
        // random mix: unmapped places and frozen cycles included
        repeat (200) begin
            r = $random(seed);
            op(r[8], ~r[8], r[9] ? 4'h0 : r[13:10], r[7:0], r[15] | r[14]);
        end
        op(0, 0, 4'h0, 8'h00, 1);
        op(0, 0, 4'h0, 8'h00, 1);
        end_of_test();
    end
endmodule // tb
`default_nettype wire

// ### rtl/pbsel_pkg.sv
/*
  Package for the port B low pin function selector: register offset,
  field positions, reset value and the route structs.
  Assumes a plain strobe register port with one-cycle read latency.
*/
package pbsel_pkg;

    // register map
    localparam logic [3:0] PBSEL_ADDR_SELECT   = 4'h0;
    localparam logic [7:0] PBSEL_SELECT_RESET  = 8'h00;
    localparam logic [7:0] PBSEL_UNMAPPED_DATA = 8'h00;
    localparam logic [7:0] PBSEL_RDATA_RESET   = 8'h00;

    // field positions (low bit of each 2-bit field)
    localparam int PBSEL_BIT3_FIELD_LSB = 6;
    localparam int PBSEL_BIT2_FIELD_LSB = 4;
    localparam int PBSEL_BIT1_FIELD_LSB = 2;
    localparam int PBSEL_BIT0_FIELD_LSB = 0;

    // route per pin, one-hot except the io codes of lines 2 and 1, which also set the shared input
    typedef struct packed {
        logic plain_io;
        logic analog_channel_one;
        logic amp_one_positive_input;
    } pbsel_line3_route_t;

    typedef struct packed {
        logic plain_io;
        logic periodic_timer_clock_in;
        logic analog_channel_six;
        logic serial_transmit;
    } pbsel_line2_route_t;

    typedef struct packed {
        logic plain_io;
        logic external_interrupt_one;
        logic analog_channel_four;
        logic crystal_pin_two;
    } pbsel_line1_route_t;

    typedef struct packed {
        logic plain_io;
        logic periodic_timer_output;
        logic analog_channel_three;
        logic crystal_pin_one;
    } pbsel_line0_route_t;

endpackage

// ### rtl/pbsel_top.sv
/*
  Port B low pin function selector: one 8-bit select register and the
  registered per-pin route decode for port B lines 0 to 3.
  Outside reset, clock enable low freezes every flop, the read data included.
  Assumes inputs synchronous to clock_in and a master that never waits.
  The routes are plain levels; the pad ring and the peripherals act on
  them, this block drives no pin itself.
*/
`timescale 1ns/1ps
`default_nettype none

module pbsel_top
    import pbsel_pkg::*;
(
    // clock, reset, enable
    input  wire logic               clock_in,
    input  wire logic               reset_n_in,
    input  wire logic               clk_en_in,
    // register port
    input  wire logic [3:0]         reg_addr_in,
    input  wire logic [7:0]         reg_wdata_in,
    input  wire logic               reg_write_in,
    input  wire logic               reg_read_in,
    output logic      [7:0]         reg_rdata_out,
    // routes
    output var pbsel_line3_route_t  line3_route_out,
    output var pbsel_line2_route_t  line2_route_out,
    output var pbsel_line1_route_t  line1_route_out,
    output var pbsel_line0_route_t  line0_route_out
);

    logic [7:0] port_b_low_function_select_ff;

    // field views, one per shared pin
    logic [1:0] bit3_pin_route_field;
    logic [1:0] bit2_pin_route_field;
    logic [1:0] bit1_pin_route_field;
    logic [1:0] bit0_pin_route_field;
    assign bit3_pin_route_field = port_b_low_function_select_ff[PBSEL_BIT3_FIELD_LSB +: 2];
    assign bit2_pin_route_field = port_b_low_function_select_ff[PBSEL_BIT2_FIELD_LSB +: 2];
    assign bit1_pin_route_field = port_b_low_function_select_ff[PBSEL_BIT1_FIELD_LSB +: 2];
    assign bit0_pin_route_field = port_b_low_function_select_ff[PBSEL_BIT0_FIELD_LSB +: 2];

    // address decode, shared by the write path, the read path and the checks
    function automatic logic hits_select(input logic [3:0] a);
        hits_select = (a == PBSEL_ADDR_SELECT);
    endfunction

    // accepted strobes; a frozen cycle accepts nothing
    logic select_write;
    logic select_read;
    assign select_write = clk_en_in && reg_write_in && hits_select(reg_addr_in);
    assign select_read  = clk_en_in && reg_read_in && hits_select(reg_addr_in);

    // decoders used for both the next routes and the assertions
    function automatic pbsel_line3_route_t dec3(input logic [1:0] f);
        dec3 = '0;
        case (f)
            2'h1:    dec3.analog_channel_one     = 1'b1;
            2'h2:    dec3.amp_one_positive_input = 1'b1;
            default: dec3.plain_io               = 1'b1;
        endcase
    endfunction

    function automatic pbsel_line2_route_t dec2(input logic [1:0] f);
        dec2 = '0;
        case (f)
            2'h1:    dec2.analog_channel_six = 1'b1;
            2'h2:    dec2.serial_transmit    = 1'b1;
            default: begin
                dec2.plain_io                = 1'b1;
                dec2.periodic_timer_clock_in = 1'b1;
            end
        endcase
    endfunction

    function automatic pbsel_line1_route_t dec1(input logic [1:0] f);
        dec1 = '0;
        case (f)
            2'h1:    dec1.analog_channel_four = 1'b1;
            2'h3:    dec1.crystal_pin_two     = 1'b1;
            default: begin
                dec1.plain_io               = 1'b1;
                dec1.external_interrupt_one = 1'b1;
            end
        endcase
    endfunction

    function automatic pbsel_line0_route_t dec0(input logic [1:0] f);
        dec0 = '0;
        case (f)
            2'h1:    dec0.periodic_timer_output = 1'b1;
            2'h2:    dec0.analog_channel_three  = 1'b1;
            2'h3:    dec0.crystal_pin_one       = 1'b1;
            default: dec0.plain_io              = 1'b1;
        endcase
    endfunction

    // next select value: the written data, so routes move on the same edge as the register
    logic [7:0] nxt_select;
    always_comb begin
        nxt_select = port_b_low_function_select_ff;
        if (select_write) begin
            nxt_select = reg_wdata_in;
        end
    end

    // select register
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            port_b_low_function_select_ff <= PBSEL_SELECT_RESET;
        end else if (clk_en_in) begin
            port_b_low_function_select_ff <= nxt_select;
        end
    end

    // routes decoded from the next value and registered, so each pin moves
    // on the same edge as the register; a field that a write leaves alone
    // keeps its flops steady, which keeps the neighbouring pins glitch free
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            line3_route_out <= dec3(PBSEL_SELECT_RESET[PBSEL_BIT3_FIELD_LSB +: 2]);
        end else if (clk_en_in) begin
            line3_route_out <= dec3(nxt_select[PBSEL_BIT3_FIELD_LSB +: 2]);
        end
    end

    // line 2 route, timer clock input rides along with plain io
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            line2_route_out <= dec2(PBSEL_SELECT_RESET[PBSEL_BIT2_FIELD_LSB +: 2]);
        end else if (clk_en_in) begin
            line2_route_out <= dec2(nxt_select[PBSEL_BIT2_FIELD_LSB +: 2]);
        end
    end

    // line 1 route, interrupt one input rides along with plain io
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            line1_route_out <= dec1(PBSEL_SELECT_RESET[PBSEL_BIT1_FIELD_LSB +: 2]);
        end else if (clk_en_in) begin
            line1_route_out <= dec1(nxt_select[PBSEL_BIT1_FIELD_LSB +: 2]);
        end
    end

    // line 0 route
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            line0_route_out <= dec0(PBSEL_SELECT_RESET[PBSEL_BIT0_FIELD_LSB +: 2]);
        end else if (clk_en_in) begin
            line0_route_out <= dec0(nxt_select[PBSEL_BIT0_FIELD_LSB +: 2]);
        end
    end

    // read data, valid only in the cycle after the read strobe
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= PBSEL_RDATA_RESET;
        end else if (clk_en_in) begin
            if (select_read) begin
                reg_rdata_out <= port_b_low_function_select_ff;
            end else begin
                reg_rdata_out <= PBSEL_UNMAPPED_DATA;
            end
        end
    end

    // checks
    a_line3_route: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        line3_route_out == dec3(bit3_pin_route_field))
        else $error("line 3 route does not match field");
    a_line2_route: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        line2_route_out == dec2(bit2_pin_route_field))
        else $error("line 2 route does not match field");
    a_line1_route: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        line1_route_out == dec1(bit1_pin_route_field))
        else $error("line 1 route does not match field");
    a_line0_route: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        line0_route_out == dec0(bit0_pin_route_field))
        else $error("line 0 route does not match field");
    a_write_applies_next: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        reset_n_in && select_write
        |=> port_b_low_function_select_ff == $past(reg_wdata_in))
        else $error("written select value not applied on next edge");
    a_readback_value: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        reset_n_in && select_read
        |=> reg_rdata_out == $past(port_b_low_function_select_ff))
        else $error("read data differs from select register");
    a_frozen_hold: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        reset_n_in && !clk_en_in |=> $stable(port_b_low_function_select_ff))
        else $error("select register changed while clock enable low");

    // line 3: each code against its fixed route, independent of the decoders
    a_line3_io: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        bit3_pin_route_field inside {2'h0, 2'h3} |-> line3_route_out == 3'h4)
        else $error("line 3 not on plain io for an io code");
    a_line3_analog: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        bit3_pin_route_field == 2'h1 |-> line3_route_out == 3'h2)
        else $error("line 3 not on analog channel one");
    a_line3_amp: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        bit3_pin_route_field == 2'h2 |-> line3_route_out == 3'h1)
        else $error("line 3 not on amplifier positive input");

    // line 2: io with timer clock, analog six, serial transmit
    a_line2_io: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        bit2_pin_route_field inside {2'h0, 2'h3} |-> line2_route_out == 4'hC)
        else $error("line 2 not on plain io with timer clock");
    a_line2_analog: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        bit2_pin_route_field == 2'h1 |-> line2_route_out == 4'h2)
        else $error("line 2 not on analog channel six");
    a_line2_transmit: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        bit2_pin_route_field == 2'h2 |-> line2_route_out == 4'h1)
        else $error("line 2 not on serial transmit");

    // line 1: io with interrupt one, analog four, crystal two
    a_line1_io: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        bit1_pin_route_field inside {2'h0, 2'h2} |-> line1_route_out == 4'hC)
        else $error("line 1 not on plain io with interrupt one");
    a_line1_analog: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        bit1_pin_route_field == 2'h1 |-> line1_route_out == 4'h2)
        else $error("line 1 not on analog channel four");
    a_line1_crystal: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        bit1_pin_route_field == 2'h3 |-> line1_route_out == 4'h1)
        else $error("line 1 not on crystal pin two");

    // line 0: io, timer output, analog three, crystal one
    a_line0_io: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        bit0_pin_route_field == 2'h0 |-> line0_route_out == 4'h8)
        else $error("line 0 not on plain io");
    a_line0_timer: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        bit0_pin_route_field == 2'h1 |-> line0_route_out == 4'h4)
        else $error("line 0 not on timer output");
    a_line0_analog: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        bit0_pin_route_field == 2'h2 |-> line0_route_out == 4'h2)
        else $error("line 0 not on analog channel three");
    a_line0_crystal: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        bit0_pin_route_field == 2'h3 |-> line0_route_out == 4'h1)
        else $error("line 0 not on crystal pin one");

    // a write that keeps a field must leave that pin alone
    a_line3_untouched: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        reset_n_in && select_write
        && reg_wdata_in[PBSEL_BIT3_FIELD_LSB +: 2] == bit3_pin_route_field
        |=> $stable(line3_route_out))
        else $error("line 3 route moved on a write that kept its field");
    a_line2_untouched: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        reset_n_in && select_write
        && reg_wdata_in[PBSEL_BIT2_FIELD_LSB +: 2] == bit2_pin_route_field
        |=> $stable(line2_route_out))
        else $error("line 2 route moved on a write that kept its field");
    a_line1_untouched: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        reset_n_in && select_write
        && reg_wdata_in[PBSEL_BIT1_FIELD_LSB +: 2] == bit1_pin_route_field
        |=> $stable(line1_route_out))
        else $error("line 1 route moved on a write that kept its field");
    a_line0_untouched: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        reset_n_in && select_write
        && reg_wdata_in[PBSEL_BIT0_FIELD_LSB +: 2] == bit0_pin_route_field
        |=> $stable(line0_route_out))
        else $error("line 0 route moved on a write that kept its field");

    // exclusive functions never overlap; the shared io inputs pair with io
    a_line3_single: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        $onehot(line3_route_out))
        else $error("line 3 route not exactly one function");
    a_line2_single: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        $onehot({line2_route_out.plain_io, line2_route_out.analog_channel_six,
                 line2_route_out.serial_transmit})
        && line2_route_out.plain_io == line2_route_out.periodic_timer_clock_in)
        else $error("line 2 route functions overlap");
    a_line1_single: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        $onehot({line1_route_out.plain_io, line1_route_out.analog_channel_four,
                 line1_route_out.crystal_pin_two})
        && line1_route_out.plain_io == line1_route_out.external_interrupt_one)
        else $error("line 1 route functions overlap");
    a_line0_single: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        $onehot(line0_route_out))
        else $error("line 0 route not exactly one function");

    // frozen cycles hold the routes and the read data too
    a_routes_frozen: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        reset_n_in && !clk_en_in
        |=> $stable(line3_route_out) && $stable(line2_route_out)
            && $stable(line1_route_out) && $stable(line0_route_out))
        else $error("route changed while clock enable low");
    a_rdata_frozen: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        reset_n_in && !clk_en_in |=> $stable(reg_rdata_out))
        else $error("read data changed while clock enable low");

    // read data fall back to the unmapped value outside the answer cycle
    a_rdata_idle: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        reset_n_in && clk_en_in && !select_read |=> reg_rdata_out == PBSEL_UNMAPPED_DATA)
        else $error("read data not back at the unmapped value");

    // writes to other places leave the register alone
    a_unmapped_write: assert property (@(posedge clock_in) disable iff (!reset_n_in)
        reset_n_in && clk_en_in && reg_write_in && !hits_select(reg_addr_in)
        |=> $stable(port_b_low_function_select_ff))
        else $error("write to another place changed the select register");

    // reset clears the register and the read data, whatever the enable
    a_reset_values: assert property (@(posedge clock_in)
        !reset_n_in |=> port_b_low_function_select_ff == PBSEL_SELECT_RESET
            && reg_rdata_out == PBSEL_RDATA_RESET && line0_route_out.plain_io)
        else $error("reset did not clear the selector");

endmodule // pbsel_top

`default_nettype wire
